// >>> shared/bam_cfg.svh
/*
 * constants for the buffer assignment and disposition block: command
 * fields, type codes, request keys and address layout.
 * assumes it is included once per compilation unit by its bare name.
 */
`ifndef BAM_CFG_SVH
`define BAM_CFG_SVH

// command type byte fields
`define BAM_TYPE_HI 2
`define BAM_MODE22_BIT 5
`define BAM_CMD_RX 3'h0
`define BAM_CMD_TX 3'h4

// disposition and response type codes
`define BAM_RX_DONE 3'h0
`define BAM_RX_UNUSED 3'h3
`define BAM_TX_DONE 3'h4
`define BAM_TX_NAK 3'h6
`define BAM_TX_NOT_SENT 3'h7
`define BAM_INFO 3'h2

// tributary addresses with a fixed meaning
`define BAM_POOL_TRIB 8'h00
`define BAM_P2P_TRIB 8'h01

// request keys, octal 6-17 and 22-37 reserved
`define BAM_KEY_HALT 6'h05
`define BAM_KEY_RSV1_LO 6'h06
`define BAM_KEY_RSV1_HI 6'h0F
`define BAM_KEY_RSV2_LO 6'h12
`define BAM_KEY_RSV2_HI 6'h1F

// address and count layout
`define BAM_CNT_HI 13
`define BAM_HI_ADDR_LSB 14
`define BAM_EXT_ADDR_HI 5
`define BAM_ADDR_W 22
`define BAM_CNT_W 14
`define BAM_RESP_W 47

`endif

// >>> shared/bam_pkg.sv
/*
 * types shared by the buffer assignment and disposition block.
 * assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none
package bam_pkg;
	// controller states
	typedef enum logic [1:0] {ST_IDLE, ST_HALT, ST_DONE} state_t;
	// line events reported by the protocol engine
	typedef enum logic [1:0] {EV_RX_DONE, EV_TX_SENT, EV_TX_ACK} ev_kind_t;
endpackage
`default_nettype wire

// >>> src/resp_fifo.sv
/*
 * small flip-flop FIFO with valid/ready on both sides.
 * assumes one clock and an active-low asynchronous reset.
 */
`default_nettype none
module resp_fifo #(
	parameter int WIDTH = 47, // word width
	parameter int DEPTH = 8 // words held
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH]; // storage
	logic [AW-1:0] wr_r; // write index
	logic [AW-1:0] rd_r; // read index
	logic [AW:0] cnt_r; // words held
	logic push;
	logic pop;

	// honest full and empty straight from the count
	assign in_ready_o = cnt_r != (AW+1)'(DEPTH);
	assign out_valid_o = cnt_r != '0;
	assign out_data_o = mem[rd_r];
	assign push = in_valid_i && in_ready_o;
	assign pop = out_valid_o && out_ready_i;

	// storage writes, no reset needed on data
	always_ff @(posedge mclk_i)
	begin
		if (push)
		begin
			mem[wr_r] <= in_data_i;
		end
	end

	// pointers and occupancy
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end
		else
		begin
			if (push)
			begin
				wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
			end
			if (pop)
			begin
				rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
			end
			if (push && !pop)
			begin
				cnt_r <= cnt_r + 1'b1;
			end
			else if (pop && !push)
			begin
				cnt_r <= cnt_r - 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

// >>> src/buffer_assign_and_disposition.sv
/*
 * buffer assignment and disposition: takes buffer assign commands,
 * holds buffers per tributary, returns them as disposition responses.
 * assumes command, control and event requesters on the same clock,
 * each holding valid until its ack pulse and dropping it then.
 */
`include "bam_cfg.svh"
`default_nettype none
module buffer_assign_and_disposition #(
	parameter int ENTRIES = 8, // buffers held at once
	parameter int RESP_DEPTH = 8 // response queue words
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// buffer assign command
	input wire logic cmd_valid_i,
	input wire logic [7:0] command_type_byte_i,
	input wire logic [7:0] tributary_address_byte_i,
	input wire logic [15:0] buffer_address_low_word_i,
	input wire logic [15:0] count_and_high_address_word_i,
	input wire logic [7:0] extended_address_byte_i,
	input wire logic [15:0] extended_count_word_i,
	output logic cmd_ack_o,
	// control command
	input wire logic ctl_valid_i,
	input wire logic [5:0] ctl_key_i,
	input wire logic [7:0] ctl_trib_i,
	input wire logic ctl_pool_wr_i,
	input wire logic ctl_pool_en_i,
	output logic ctl_ack_o,
	// line events
	input wire logic ev_valid_i,
	input wire bam_pkg::ev_kind_t ev_kind_i,
	input wire logic [7:0] ev_trib_i,
	input wire logic [13:0] ev_len_i,
	output logic ev_ack_o,
	output logic ev_nobuf_o,
	// configuration and status
	input wire logic multipoint_i,
	output logic addr22_mode_o,
	output logic proc_err_o,
	// responses
	output logic resp_valid_o,
	input wire logic resp_ready_i,
	output logic [2:0] resp_type_o,
	output logic [7:0] resp_trib_o,
	output logic [21:0] resp_addr_o,
	output logic [13:0] resp_count_o
);
	import bam_pkg::*;
	localparam int IW = $clog2(ENTRIES);

	// every assertion below shares the one clock and the reset
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!reset_n_i);

	// buffer table, kept oldest first
	logic e_tx [ENTRIES]; // transmit buffer
	logic e_sent [ENTRIES]; // sent, awaiting acknowledge
	logic [7:0] e_trib [ENTRIES]; // owner, zero for pool
	logic [21:0] e_addr [ENTRIES]; // buffer address
	logic [13:0] e_cnt [ENTRIES]; // byte count
	logic [IW:0] n_r; // entries in use

	state_t st_r; // controller state
	logic [IW-1:0] idx_r; // halt scan position
	logic [7:0] htrib_r; // tributary being halted
	logic [255:0] pool_en_r; // per tributary pool access

	// masks and picks
	logic [ENTRIES-1:0] m_priv, m_pool, m_unsent, m_sent;
	logic [IW:0] f_priv, f_pool, f_unsent, f_sent;
	// accept slot
	logic go, take_ctl, take_ev, take_cmd;
	// command decode
	logic mode22, cmd_bad, key_rsv;
	logic [2:0] cmd_type;
	logic [21:0] cmd_addr;
	logic [13:0] cmd_cnt;
	// actions of this cycle
	logic push_en, rm_en, mark_en, err, nobuf;
	logic [IW-1:0] rm_idx, mark_idx;
	logic [2:0] push_type;
	logic [7:0] push_trib;
	logic [21:0] push_addr;
	logic [13:0] push_cnt;
	logic h_hit;
	// fifo links
	logic f_in_rdy, f_out_valid, f_out_rdy;
	logic [`BAM_RESP_W-1:0] f_out_data;

	// oldest set bit of a mask, found flag on top
	function automatic logic [IW:0] first_idx(logic [ENTRIES-1:0] m);
		logic [IW:0] r;
		r = '0;
		for (int i = ENTRIES - 1; i >= 0; i--)
		begin
			if (m[i])
			begin
				r = {1'b1, IW'(i)};
			end
		end
		return r;
	endfunction

	// one request per cycle, and none in the cycle of an ack so
	// a still-high valid is not taken twice
	always_comb
	begin
		go = (st_r == ST_IDLE) && f_in_rdy &&
			!(cmd_ack_o || ctl_ack_o || ev_ack_o);
		take_ctl = go && ctl_valid_i;
		take_ev = go && !ctl_valid_i && ev_valid_i;
		take_cmd = go && !ctl_valid_i && !ev_valid_i && cmd_valid_i;
	end

	// command field decode
	always_comb
	begin
		mode22 = command_type_byte_i[`BAM_MODE22_BIT];
		cmd_type = command_type_byte_i[`BAM_TYPE_HI:0];
		if (mode22)
		begin
			// upper address from the extended byte, count moved
			cmd_addr = {extended_address_byte_i[`BAM_EXT_ADDR_HI:0],
				buffer_address_low_word_i};
			cmd_cnt = extended_count_word_i[`BAM_CNT_HI:0];
		end
		else
		begin
			// 18-bit address, count in the low 14 bits
			cmd_addr = {4'h0,
				count_and_high_address_word_i[15:`BAM_HI_ADDR_LSB],
				buffer_address_low_word_i};
			cmd_cnt = count_and_high_address_word_i[`BAM_CNT_HI:0];
		end
		// refused: zero count, unknown type, transmit to zero, full
		cmd_bad = (cmd_cnt == '0) ||
			(cmd_type != `BAM_CMD_RX && cmd_type != `BAM_CMD_TX) ||
			(cmd_type == `BAM_CMD_TX &&
			tributary_address_byte_i == `BAM_POOL_TRIB) ||
			(n_r == (IW+1)'(ENTRIES));
		key_rsv = (ctl_key_i >= `BAM_KEY_RSV1_LO &&
			ctl_key_i <= `BAM_KEY_RSV1_HI) ||
			(ctl_key_i >= `BAM_KEY_RSV2_LO &&
			ctl_key_i <= `BAM_KEY_RSV2_HI);
	end

	// candidate buffers for the event's tributary
	always_comb
	begin
		for (int i = 0; i < ENTRIES; i++)
		begin
			m_priv[i] = (i < int'(n_r)) && !e_tx[i] &&
				ev_trib_i != `BAM_POOL_TRIB &&
				e_trib[i] == ev_trib_i;
			m_pool[i] = (i < int'(n_r)) && !e_tx[i] &&
				e_trib[i] == `BAM_POOL_TRIB &&
				pool_en_r[ev_trib_i];
			m_unsent[i] = (i < int'(n_r)) && e_tx[i] && !e_sent[i] &&
				e_trib[i] == ev_trib_i;
			m_sent[i] = (i < int'(n_r)) && e_tx[i] && e_sent[i] &&
				e_trib[i] == ev_trib_i;
		end
		f_priv = first_idx(m_priv);
		f_pool = first_idx(m_pool);
		f_unsent = first_idx(m_unsent); // oldest first
		f_sent = first_idx(m_sent);
	end

	// actions: responses, table removals, marks, errors
	always_comb
	begin
		push_en = 1'b0;
		push_type = `BAM_RX_DONE;
		push_trib = htrib_r;
		push_addr = '0;
		push_cnt = '0;
		rm_en = 1'b0;
		rm_idx = '0;
		mark_en = 1'b0;
		mark_idx = '0;
		err = 1'b0;
		nobuf = 1'b0;
		h_hit = (idx_r < n_r[IW-1:0] || n_r == (IW+1)'(ENTRIES)) &&
			(int'(idx_r) < int'(n_r)) &&
			((htrib_r == `BAM_POOL_TRIB) ?
			(!e_tx[idx_r] && e_trib[idx_r] == `BAM_POOL_TRIB) :
			(e_trib[idx_r] == htrib_r));
		if (take_cmd && cmd_bad)
		begin
			err = 1'b1;
		end
		if (take_ctl && key_rsv)
		begin
			err = 1'b1;
		end
		if (take_ev)
		begin
			push_trib = ev_trib_i;
			case (ev_kind_i)
				EV_RX_DONE:
				begin
					// private first, then the pool
					if (f_priv[IW] || f_pool[IW])
					begin
						rm_en = 1'b1;
						rm_idx = f_priv[IW] ? f_priv[IW-1:0] : f_pool[IW-1:0];
						push_en = 1'b1;
						push_type = `BAM_RX_DONE;
						push_addr = e_addr[rm_idx];
						push_cnt = ev_len_i;
					end
					else
					begin
						nobuf = 1'b1; // no buffer to store into
					end
				end
				EV_TX_SENT:
				begin
					mark_en = f_unsent[IW];
					mark_idx = f_unsent[IW-1:0];
				end
				EV_TX_ACK:
				begin
					// only an acknowledged buffer completes
					if (f_sent[IW])
					begin
						rm_en = 1'b1;
						rm_idx = f_sent[IW-1:0];
						push_en = 1'b1;
						push_type = `BAM_TX_DONE;
						push_addr = e_addr[rm_idx];
						push_cnt = e_cnt[rm_idx];
					end
				end
				default:
				begin
					nobuf = 1'b0;
				end
			endcase
		end
		if (st_r == ST_HALT && h_hit && f_in_rdy)
		begin
			// one response per returned buffer
			rm_en = 1'b1;
			rm_idx = idx_r;
			push_en = 1'b1;
			push_addr = e_addr[idx_r];
			push_cnt = e_cnt[idx_r];
			if (!e_tx[idx_r])
			begin
				push_type = `BAM_RX_UNUSED;
			end
			else if (e_sent[idx_r])
			begin
				push_type = `BAM_TX_NAK;
			end
			else
			begin
				push_type = `BAM_TX_NOT_SENT;
			end
		end
		if (st_r == ST_DONE)
		begin
			push_en = 1'b1; // completion of the pool return
			push_type = `BAM_INFO;
		end
		if (!multipoint_i)
		begin
			push_trib = `BAM_P2P_TRIB;
		end
	end

	// buffer table: insert at the tail, remove with compaction so the
	// table stays in assignment order
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			n_r <= '0;
			for (int i = 0; i < ENTRIES; i++)
			begin
				e_tx[i] <= 1'b0;
				e_sent[i] <= 1'b0;
				e_trib[i] <= '0;
				e_addr[i] <= '0;
				e_cnt[i] <= '0;
			end
		end
		else if (rm_en)
		begin
			for (int i = 0; i < ENTRIES - 1; i++)
			begin
				if (i >= int'(rm_idx))
				begin
					e_tx[i] <= e_tx[i+1];
					e_sent[i] <= e_sent[i+1];
					e_trib[i] <= e_trib[i+1];
					e_addr[i] <= e_addr[i+1];
					e_cnt[i] <= e_cnt[i+1];
				end
			end
			n_r <= n_r - 1'b1;
		end
		else if (mark_en)
		begin
			e_sent[mark_idx] <= 1'b1;
		end
		else if (take_cmd && !cmd_bad)
		begin
			// one buffer per command, kind kept apart
			// trib zero receive buffers form the pool
			e_tx[n_r[IW-1:0]] <= (cmd_type == `BAM_CMD_TX);
			e_sent[n_r[IW-1:0]] <= 1'b0;
			e_trib[n_r[IW-1:0]] <= tributary_address_byte_i;
			e_addr[n_r[IW-1:0]] <= cmd_addr;
			e_cnt[n_r[IW-1:0]] <= cmd_cnt;
			n_r <= n_r + 1'b1;
		end
	end

	// controller state and halt scan; a hit holds the index since
	// compaction brings the next entry into place
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			st_r <= ST_IDLE;
			idx_r <= '0;
			htrib_r <= '0;
		end
		else
		begin
			case (st_r)
				ST_IDLE:
				begin
					if (take_ctl && ctl_key_i == `BAM_KEY_HALT)
					begin
						st_r <= ST_HALT;
						idx_r <= '0;
						htrib_r <= ctl_trib_i;
					end
				end
				ST_HALT:
				begin
					if (int'(idx_r) >= int'(n_r))
					begin
						st_r <= (htrib_r == `BAM_POOL_TRIB) ? ST_DONE :
							ST_IDLE;
					end
					else if (!h_hit)
					begin
						if (int'(idx_r) == ENTRIES - 1)
						begin
							st_r <= (htrib_r == `BAM_POOL_TRIB) ? ST_DONE :
								ST_IDLE;
						end
						else
						begin
							idx_r <= idx_r + 1'b1;
						end
					end
				end
				ST_DONE:
				begin
					if (f_in_rdy)
					begin
						st_r <= ST_IDLE;
					end
				end
				default:
				begin
					st_r <= ST_IDLE;
				end
			endcase
		end
	end

	// per tributary pool access, written by control commands
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			pool_en_r <= '0;
		end
		else if (take_ctl && !key_rsv && ctl_pool_wr_i)
		begin
			pool_en_r[ctl_trib_i] <= ctl_pool_en_i;
		end
	end

	// acks, status pulses and the retained address mode
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			cmd_ack_o <= 1'b0;
			ctl_ack_o <= 1'b0;
			ev_ack_o <= 1'b0;
			ev_nobuf_o <= 1'b0;
			proc_err_o <= 1'b0;
			addr22_mode_o <= 1'b0;
		end
		else
		begin
			cmd_ack_o <= take_cmd;
			ctl_ack_o <= take_ctl;
			ev_ack_o <= take_ev;
			ev_nobuf_o <= nobuf;
			proc_err_o <= err;
			if (take_cmd)
			begin
				addr22_mode_o <= mode22;
			end
		end
	end

	// response queue; a stalled reader fills it and then stops intake
	resp_fifo #(
		.WIDTH(`BAM_RESP_W),
		.DEPTH(RESP_DEPTH)
	) u_fifo (
		.mclk_i(mclk_i),
		.reset_n_i(reset_n_i),
		.in_valid_i(push_en),
		.in_ready_o(f_in_rdy),
		.in_data_i({push_type, push_trib, push_addr, push_cnt}),
		.out_valid_o(f_out_valid),
		.out_ready_i(f_out_rdy),
		.out_data_o(f_out_data)
	);

	// output stage so every response port comes from a flop
	assign f_out_rdy = !resp_valid_o || resp_ready_i;
	always_ff @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			resp_valid_o <= 1'b0;
			resp_type_o <= '0;
			resp_trib_o <= '0;
			resp_addr_o <= '0;
			resp_count_o <= '0;
		end
		else if (f_out_rdy)
		begin
			resp_valid_o <= f_out_valid;
			if (f_out_valid)
			begin
				{resp_type_o, resp_trib_o, resp_addr_o, resp_count_o} <=
					f_out_data;
			end
		end
	end

	a_zero_count: assert property (take_cmd && cmd_cnt == '0 |=>
		proc_err_o && n_r == $past(n_r)) else $error("zero count taken");
	a_tx_trib_zero: assert property (take_cmd &&
		cmd_type == `BAM_CMD_TX &&
		tributary_address_byte_i == `BAM_POOL_TRIB
		|=> proc_err_o) else $error("tx to trib zero not refused");
	a_key_reserved: assert property (take_ctl && key_rsv
		|=> proc_err_o) else $error("reserved key not refused");
	a_mode_kept: assert property (take_cmd |=>
		addr22_mode_o == $past(mode22)) else $error("mode not retained");
	a_insert_one: assert property (take_cmd && !cmd_bad |=>
		n_r == $past(n_r) + 1'b1) else $error("assign not stored");
	a_p2p_trib: assert property (push_en && !multipoint_i |->
		push_trib == `BAM_P2P_TRIB) else $error("p2p trib not one");
	a_ack_only: assert property (push_en &&
		push_type == `BAM_TX_DONE
		|-> take_ev && ev_kind_i == EV_TX_ACK && f_sent[IW])
		else $error("tx complete without ack");
	a_halt_codes: assert property (st_r == ST_HALT && push_en |->
		push_type inside {`BAM_RX_UNUSED, `BAM_TX_NAK,
		`BAM_TX_NOT_SENT}) else $error("bad halt code");
	a_pool_info: assert property (st_r == ST_HALT &&
		htrib_r == `BAM_POOL_TRIB && int'(idx_r) >= int'(n_r) |=>
		st_r == ST_DONE ##[0:8] push_type == `BAM_INFO)
		else $error("pool return without info");

	c_assign: cover property (take_cmd && !cmd_bad);
	c_rx_pool: cover property (take_ev && !f_priv[IW] && f_pool[IW]);
	c_halt_done: cover property (st_r == ST_HALT ##1 st_r == ST_IDLE);
	c_full_stall: cover property (!f_in_rdy && resp_valid_o);
endmodule
`default_nettype wire

// >>> tb/resp_host.sv
/*
 * response consumer model: stands for host software taking disposition
 * and information responses off the block's response port.
 * assumes the block's registered valid/ready port on mclk_i.
 */
`default_nettype none
module resp_host (
	// clock and reset
	input wire logic mclk_i,
	input wire logic reset_n_i,
	// bench control
	input wire logic stall_i,
	// response port
	input wire logic resp_valid_i,
	output logic resp_ready_o,
	input wire logic [46:0] resp_word_i
);
	timeunit 1ns;
	timeprecision 1ps;
	// words taken, oldest first
	logic [46:0] q[$];
	// ready moves just after an edge, so a stall never cuts a cycle short
	always @(posedge mclk_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			resp_ready_o <= 1'h0;
		else
			resp_ready_o <= !stall_i;
	end
	// a buffer's contents count only once its word is taken here
	always @(posedge mclk_i)
	begin
		if (reset_n_i && resp_valid_i && resp_ready_o)
			q.push_back(resp_word_i);
	end
endmodule
`default_nettype wire

// >>> tb/buffer_assign_and_disposition_tb.sv
/*
 * self-checking bench for the buffer assignment and disposition block.
 * assumes the response host model and the shared package are compiled.
 */
`default_nettype none
module buffer_assign_and_disposition_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// clock, reset and the command, control and event requesters
	logic mclk_i = 1'h0, reset_n_i = 1'h0, stall = 1'h0, e;
	logic cmd_valid_i = 1'h0, ctl_valid_i = 1'h0, ev_valid_i = 1'h0;
	logic [7:0] command_type_byte_i = 8'h0, tributary_address_byte_i = 8'h0;
	logic [15:0] buffer_address_low_word_i = 16'h0;
	logic [15:0] count_and_high_address_word_i = 16'h0;
	logic [7:0] extended_address_byte_i = 8'h0, ctl_trib_i = 8'h0;
	logic [15:0] extended_count_word_i = 16'h0;
	logic [5:0] ctl_key_i = 6'h0;
	logic ctl_pool_wr_i = 1'h0, ctl_pool_en_i = 1'h0, multipoint_i = 1'h1;
	bam_pkg::ev_kind_t ev_kind_i = bam_pkg::EV_RX_DONE;
	logic [7:0] ev_trib_i = 8'h0;
	logic [13:0] ev_len_i = 14'h0;
	// design outputs
	logic cmd_ack_o, ctl_ack_o, ev_ack_o, ev_nobuf_o, addr22_mode_o;
	logic proc_err_o, resp_valid_o, resp_ready_i;
	logic [2:0] resp_type_o;
	logic [7:0] resp_trib_o;
	logic [21:0] resp_addr_o;
	logic [13:0] resp_count_o;
	int n_mismatch = 0, check_count = 0;

	buffer_assign_and_disposition dut (
		.mclk_i(mclk_i), .reset_n_i(reset_n_i), .cmd_valid_i(cmd_valid_i),
		.command_type_byte_i(command_type_byte_i),
		.tributary_address_byte_i(tributary_address_byte_i),
		.buffer_address_low_word_i(buffer_address_low_word_i),
		.count_and_high_address_word_i(count_and_high_address_word_i),
		.extended_address_byte_i(extended_address_byte_i),
		.extended_count_word_i(extended_count_word_i), .cmd_ack_o(cmd_ack_o),
		.ctl_valid_i(ctl_valid_i), .ctl_key_i(ctl_key_i),
		.ctl_trib_i(ctl_trib_i), .ctl_pool_wr_i(ctl_pool_wr_i),
		.ctl_pool_en_i(ctl_pool_en_i), .ctl_ack_o(ctl_ack_o),
		.ev_valid_i(ev_valid_i), .ev_kind_i(ev_kind_i), .ev_trib_i(ev_trib_i),
		.ev_len_i(ev_len_i), .ev_ack_o(ev_ack_o), .ev_nobuf_o(ev_nobuf_o),
		.multipoint_i(multipoint_i), .addr22_mode_o(addr22_mode_o),
		.proc_err_o(proc_err_o), .resp_valid_o(resp_valid_o),
		.resp_ready_i(resp_ready_i), .resp_type_o(resp_type_o),
		.resp_trib_o(resp_trib_o), .resp_addr_o(resp_addr_o),
		.resp_count_o(resp_count_o)
	);
	resp_host host (
		.mclk_i(mclk_i), .reset_n_i(reset_n_i), .stall_i(stall),
		.resp_valid_i(resp_valid_o), .resp_ready_o(resp_ready_i),
		.resp_word_i({resp_type_o, resp_trib_o, resp_addr_o, resp_count_o})
	);

	// free-running 100 MHz clock
	initial
	begin
		forever #5 mclk_i = ~mclk_i;
	end

	// verdict and end of run, reached from the main sequence or the watchdog
	task test_done;
		if (n_mismatch == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// one comparison: counted, a mismatch reported at once
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// waits, bounded, for ack k (0 cmd, 1 ctl, 2 ev); e is the pulse with it
	task automatic await(input int k, output logic e);
		int n;
		logic a;
		n = 0;
		a = 1'h0;
		while (a !== 1'h1 && n < 60)
		begin
			@(posedge mclk_i);
			n++;
			a = (k == 0) ? cmd_ack_o : (k == 1) ? ctl_ack_o : ev_ack_o;
		end
		e = (k == 2) ? ev_nobuf_o : proc_err_o;
		chk(64'(n < 60), 64'h1); // the ack came in time
	endtask

	// one buffer per command, request held until its ack
	task automatic cmd(input logic [7:0] t, r, input logic [15:0] l, h,
		input logic [7:0] x, input logic [15:0] c);
		cmd_valid_i <= 1'h1;
		command_type_byte_i <= t;
		tributary_address_byte_i <= r;
		buffer_address_low_word_i <= l;
		count_and_high_address_word_i <= h;
		extended_address_byte_i <= x;
		extended_count_word_i <= c;
		await(0, e);
		cmd_valid_i <= 1'h0;
		@(posedge mclk_i);
	endtask

	// control command, held until its ack
	task automatic ctl(input logic [5:0] k, input logic [7:0] r,
		input logic w, en);
		ctl_valid_i <= 1'h1;
		ctl_key_i <= k;
		ctl_trib_i <= r;
		ctl_pool_wr_i <= w;
		ctl_pool_en_i <= en;
		await(1, e);
		ctl_valid_i <= 1'h0;
		@(posedge mclk_i);
	endtask

	// line event, held until its ack
	task automatic ev(input bam_pkg::ev_kind_t k, input logic [7:0] r,
		input logic [13:0] n);
		ev_valid_i <= 1'h1;
		ev_kind_i <= k;
		ev_trib_i <= r;
		ev_len_i <= n;
		await(2, e);
		ev_valid_i <= 1'h0;
		@(posedge mclk_i);
	endtask

	// takes the next response (bounded wait); w low compares type and trib
	task automatic resp(input logic w, input logic [46:0] x);
		int n;
		logic [46:0] g;
		n = 0;
		g = 47'h0;
		while (host.q.size() == 0 && n < 100)
		begin
			@(posedge mclk_i);
			n++;
		end
		if (host.q.size() != 0)
			g = host.q.pop_front();
		chk(64'(n < 100), 64'h1); // a response came in time
		if (w)
			chk(64'(g), 64'(x));
		else
			chk(64'(g[46:36]), 64'(x[46:36]));
	endtask

	// private receive buffer filled; refusals and reserved keys
	task s_rx;
		cmd(8'h00, 8'h03, 16'h1234, 16'h8010, 8'h2A, 16'h3FFF);
		chk(e, 1'h0);
		ev(bam_pkg::EV_RX_DONE, 8'h03, 14'h0020);
		chk(e, 1'h0);
		resp(1'h1, {3'h0, 8'h03, 22'h021234, 14'h0020});
		cmd(8'h00, 8'h03, 16'h1234, 16'hC000, 8'h00, 16'h0001);
		chk(e, 1'h1);
		cmd(8'h01, 8'h03, 16'h1234, 16'h0001, 8'h00, 16'h0001);
		chk(e, 1'h1);
		cmd(8'h04, 8'h00, 16'h1234, 16'h0001, 8'h00, 16'h0001);
		chk(e, 1'h1);
		for (int k = 6; k < 32; k++)
		begin
			if (k < 16 || k > 17)
			begin
				ctl(6'(k), 8'h05, 1'h1, 1'h1);
				chk(e, 1'h1);
			end
		end
		chk(64'(host.q.size()), 64'h0);
	endtask

	// pool gated per tributary; private taken before pool; halt returns
	task s_pool;
		cmd(8'h00, 8'h00, 16'h4000, 16'h0040, 8'h00, 16'h0000);
		cmd(8'h00, 8'h03, 16'h5000, 16'h4040, 8'h00, 16'h0000);
		ev(bam_pkg::EV_RX_DONE, 8'h05, 14'h0010);
		chk(e, 1'h1);
		ctl(6'h03, 8'h05, 1'h1, 1'h1);
		chk(e, 1'h0);
		cmd(8'h00, 8'h05, 16'h6000, 16'h0080, 8'h00, 16'h0000);
		ev(bam_pkg::EV_RX_DONE, 8'h05, 14'h0011);
		resp(1'h1, {3'h0, 8'h05, 22'h006000, 14'h0011});
		ev(bam_pkg::EV_RX_DONE, 8'h05, 14'h0012);
		resp(1'h1, {3'h0, 8'h05, 22'h004000, 14'h0012});
		ev(bam_pkg::EV_RX_DONE, 8'h05, 14'h0001);
		chk(e, 1'h1);
		ctl(6'h05, 8'h03, 1'h0, 1'h0);
		resp(1'h1, {3'h0 + 3'h3, 8'h03, 22'h015000, 14'h0040});
	endtask

	// transmit complete needs ack; halt returns 011, 110, 111 in age order
	task s_tx;
		cmd(8'h00, 8'h02, 16'h7000, 16'h0008, 8'h00, 16'h0000);
		cmd(8'h04, 8'h02, 16'h8000, 16'h0100, 8'h00, 16'h0000);
		cmd(8'h04, 8'h02, 16'h9000, 16'h0200, 8'h00, 16'h0000);
		ev(bam_pkg::EV_TX_SENT, 8'h02, 14'h0000);
		repeat (5) @(posedge mclk_i);
		chk(64'(host.q.size()), 64'h0);
		ev(bam_pkg::EV_TX_ACK, 8'h02, 14'h0000);
		resp(1'h1, {3'h4, 8'h02, 22'h008000, 14'h0100});
		ev(bam_pkg::EV_TX_SENT, 8'h02, 14'h0000);
		cmd(8'h04, 8'h02, 16'hA000, 16'h0300, 8'h00, 16'h0000);
		ctl(6'h05, 8'h02, 1'h0, 1'h0);
		resp(1'h1, {3'h3, 8'h02, 22'h007000, 14'h0008});
		resp(1'h1, {3'h6, 8'h02, 22'h009000, 14'h0200});
		resp(1'h1, {3'h7, 8'h02, 22'h00A000, 14'h0300});
		repeat (10) @(posedge mclk_i);
		chk(64'(host.q.size()), 64'h0);
	endtask

	// 22-bit layout, mode bit retained, point-to-point tributary one
	task s_mode;
		cmd(8'h24, 8'h04, 16'hBEEF, 16'hC000, 8'hFF, 16'h0123);
		chk(e, 1'h0);
		chk(addr22_mode_o, 1'h1);
		ev(bam_pkg::EV_TX_SENT, 8'h04, 14'h0000);
		ev(bam_pkg::EV_TX_ACK, 8'h04, 14'h0000);
		resp(1'h1, {3'h4, 8'h04, 22'h3FBEEF, 14'h0123});
		multipoint_i <= 1'h0;
		cmd(8'h00, 8'h07, 16'h1111, 16'h0001, 8'h3F, 16'h0000);
		chk(addr22_mode_o, 1'h0);
		ev(bam_pkg::EV_RX_DONE, 8'h07, 14'h0005);
		resp(1'h1, {3'h0, 8'h01, 22'h001111, 14'h0005});
		multipoint_i <= 1'h1;
	endtask

	// full table refuses; pool drained through a stalled queue, then info
	task s_fill;
		for (int i = 0; i < 8; i++)
			cmd(8'h00, 8'h00, 16'(i * 256), 16'h0004, 8'h00, 16'h0000);
		cmd(8'h00, 8'h00, 16'hFF00, 16'h0004, 8'h00, 16'h0000);
		chk(e, 1'h1);
		ctl(6'h03, 8'h05, 1'h1, 1'h0);
		ev(bam_pkg::EV_RX_DONE, 8'h05, 14'h0001);
		chk(e, 1'h1);
		stall <= 1'h1;
		ctl(6'h05, 8'h00, 1'h0, 1'h0);
		repeat (40) @(posedge mclk_i);
		chk(64'(host.q.size()), 64'h0);
		stall <= 1'h0;
		for (int i = 0; i < 8; i++)
			resp(1'h1, {3'h3, 8'h00, 22'(i * 256), 14'h0004});
		resp(1'h0, {3'h2, 8'h00, 36'h0});
	endtask

	// reset held three cycles, then the scenarios in turn
	initial
	begin
		repeat (3) @(posedge mclk_i);
		reset_n_i <= 1'h1;
		@(posedge mclk_i);
		s_rx();
		s_pool();
		s_tx();
		s_mode();
		s_fill();
		test_done();
	end

	// watchdog: the run needs a few hundred cycles, allow 20000
	initial
	begin
		#200000;
		n_mismatch++;
		test_done();
	end
endmodule
`default_nettype wire
